/* File: hsis_pkg.sv */
// constants for the host serial interface select block
package hsis_pkg;
  localparam int unsigned clk_hz = 125000000;
  localparam int unsigned uart_slow_bps = 19200;
  localparam int unsigned uart_fast_bps = 38400;
  localparam int unsigned spi_slow_bps = 125000;
  localparam int unsigned spi_fast_bps = 500000;
  // cycles per bit, rounded down
  localparam logic [12:0] uart_slow_cyc = 13'(clk_hz / uart_slow_bps);
  localparam logic [12:0] uart_fast_cyc = 13'(clk_hz / uart_fast_bps);
  // cycles per half spi clock period
  localparam logic [12:0] spi_slow_half = 13'(clk_hz / (2 * spi_slow_bps));
  localparam logic [12:0] spi_fast_half = 13'(clk_hz / (2 * spi_fast_bps));
  localparam logic [3:0] data_bits = 4'h8;
  localparam logic [3:0] frame9_bits = 4'ha;
  localparam logic [3:0] frame8_bits = 4'h9;
  typedef enum logic [3:0] {
    hsis_mode_uart = 4'b0001,
    hsis_mode_analog = 4'b0010,
    hsis_mode_spi = 4'b0100,
    hsis_mode_none = 4'b1000
  } hsis_mode_t;
  typedef enum logic [2:0] {
    hsis_spi_idle = 3'b001,
    hsis_spi_low = 3'b010,
    hsis_spi_high = 3'b100
  } hsis_spi_t;
endpackage : hsis_pkg

/* File: hsis_top.sv */
// mode-selected uart, spi master or analog pass-through toward the host
module hsis_top (
  input wire logic mclk,
  input wire logic rst,
  input wire logic transfer_request_in,
  input wire logic iface_select_a,
  input wire logic iface_select_b,
  input wire logic uart_format_select,
  input wire logic uart_rate_select,
  output logic format_clock_out,
  output logic format_clock_oe,
  output logic rate_select_oe,
  output logic slave_select_out,
  input wire logic host_to_device_serial,
  output logic device_to_host_serial,
  input wire logic bus_rx_level,
  output logic bus_tx_level,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_parity_err,
  output logic frame_state_enable,
  output logic [3:0] active_mode
);
  // two-flop synchronisers for all pins
  logic [6:0] pin_s1_reg;
  logic [6:0] pin_s2_reg;
  logic [6:0] pin_raw;
  assign pin_raw = {bus_rx_level, host_to_device_serial, uart_rate_select, uart_format_select,
                    iface_select_b, iface_select_a, transfer_request_in};
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_s1_reg <= 7'h7f;
      pin_s2_reg <= 7'h7f;
    end else begin
      pin_s1_reg <= pin_raw;
      pin_s2_reg <= pin_s1_reg;
    end
  end
  logic req_s, sel_a_s, sel_b_s, fmt_s, rate_s, sdi_s, brx_s;
  assign {brx_s, sdi_s, rate_s, fmt_s, sel_b_s, sel_a_s, req_s} = pin_s2_reg;

  // strap capture a few cycles after release, once synchronisers hold pin levels
  logic [1:0] settle_reg, settle_next;
  logic latched_reg, latched_next;
  hsis_pkg::hsis_mode_t mode_reg, mode_next;
  logic fmt8_reg, fmt8_next, fast_reg, fast_next;
  always_comb begin
    settle_next = settle_reg;
    latched_next = latched_reg;
    mode_next = mode_reg;
    fmt8_next = fmt8_reg;
    fast_next = fast_reg;
    if (!latched_reg) begin
      if (settle_reg != 2'h3) begin
        settle_next = settle_reg + 2'h1;
      end else begin
        latched_next = 1'b1;
        fmt8_next = fmt_s;
        if (!sel_a_s && !sel_b_s) begin
          mode_next = req_s ? hsis_pkg::hsis_mode_analog : hsis_pkg::hsis_mode_uart;
          fast_next = rate_s;
        end else if (sel_a_s != sel_b_s) begin
          mode_next = hsis_pkg::hsis_mode_spi;
          fast_next = sel_b_s;
        end else begin
          mode_next = hsis_pkg::hsis_mode_none;
        end
      end
    end
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      settle_reg <= 2'h0;
      latched_reg <= 1'b0;
      mode_reg <= hsis_pkg::hsis_mode_none;
      fmt8_reg <= 1'b0;
      fast_reg <= 1'b0;
    end else begin
      settle_reg <= settle_next;
      latched_reg <= latched_next;
      mode_reg <= mode_next;
      fmt8_reg <= fmt8_next;
      fast_reg <= fast_next;
    end
  end
  logic is_uart, is_spi, is_analog;
  assign is_uart = latched_reg && mode_reg == hsis_pkg::hsis_mode_uart;
  assign is_spi = latched_reg && mode_reg == hsis_pkg::hsis_mode_spi;
  assign is_analog = latched_reg && mode_reg == hsis_pkg::hsis_mode_analog;
  logic [12:0] bit_cyc;
  assign bit_cyc = fast_reg ? hsis_pkg::uart_fast_cyc : hsis_pkg::uart_slow_cyc;
  logic [3:0] frame_len;
  assign frame_len = fmt8_reg ? hsis_pkg::frame8_bits : hsis_pkg::frame9_bits;

  // uart transmitter: start, 8 data lsb first, optional even parity, stop
  logic tx_busy_reg, tx_busy_next;
  logic [12:0] tx_cnt_reg, tx_cnt_next;
  logic [3:0] tx_bit_reg, tx_bit_next;
  logic [9:0] tx_sh_reg, tx_sh_next;
  logic utx_line_reg, utx_line_next;
  always_comb begin
    tx_busy_next = tx_busy_reg;
    tx_cnt_next = tx_cnt_reg;
    tx_bit_next = tx_bit_reg;
    tx_sh_next = tx_sh_reg;
    utx_line_next = utx_line_reg;
    if (!tx_busy_reg) begin
      utx_line_next = 1'b1;
      if (is_uart && tx_valid) begin
        tx_busy_next = 1'b1;
        tx_sh_next = {1'b1, ^tx_data, tx_data};
        utx_line_next = 1'b0;
        tx_cnt_next = 13'h0;
        tx_bit_next = 4'h0;
      end
    end else if (tx_cnt_reg == bit_cyc - 13'h1) begin
      tx_cnt_next = 13'h0;
      if (tx_bit_reg == frame_len) begin
        tx_busy_next = 1'b0;
        utx_line_next = 1'b1;
      end else begin
        tx_bit_next = tx_bit_reg + 4'h1;
        utx_line_next = (fmt8_reg && tx_bit_reg == hsis_pkg::data_bits) ? 1'b1 : tx_sh_reg[0];
        tx_sh_next = {1'b1, tx_sh_reg[9:1]};
      end
    end else begin
      tx_cnt_next = tx_cnt_reg + 13'h1;
    end
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_busy_reg <= 1'b0;
      tx_cnt_reg <= 13'h0;
      tx_bit_reg <= 4'h0;
      tx_sh_reg <= 10'h3ff;
      utx_line_reg <= 1'b1;
    end else begin
      tx_busy_reg <= tx_busy_next;
      tx_cnt_reg <= tx_cnt_next;
      tx_bit_reg <= tx_bit_next;
      tx_sh_reg <= tx_sh_next;
      utx_line_reg <= utx_line_next;
    end
  end

  // uart receiver, independent of the transmitter
  logic rx_busy_reg, rx_busy_next;
  logic [12:0] rx_cnt_reg, rx_cnt_next;
  logic [3:0] rx_bit_reg, rx_bit_next;
  logic [8:0] rx_sh_reg, rx_sh_next;
  logic urx_valid_reg, urx_valid_next;
  logic [7:0] urx_data_reg, urx_data_next;
  logic urx_perr_reg, urx_perr_next;
  always_comb begin
    rx_busy_next = rx_busy_reg;
    rx_cnt_next = rx_cnt_reg;
    rx_bit_next = rx_bit_reg;
    rx_sh_next = rx_sh_reg;
    urx_valid_next = 1'b0;
    urx_data_next = urx_data_reg;
    urx_perr_next = urx_perr_reg;
    if (!rx_busy_reg) begin
      if (is_uart && !sdi_s) begin
        rx_busy_next = 1'b1;
        rx_cnt_next = {1'b0, bit_cyc[12:1]};
        rx_bit_next = 4'h0;
      end
    end else if (rx_cnt_reg == bit_cyc - 13'h1) begin
      rx_cnt_next = 13'h0;
      rx_bit_next = rx_bit_reg + 4'h1;
      if (rx_bit_reg == 4'h0 && sdi_s) begin
        rx_busy_next = 1'b0; // false start
      end else if (rx_bit_reg == frame_len - 4'h1) begin
        rx_busy_next = 1'b0;
        urx_valid_next = 1'b1;
        // the last data or parity bit is sampled in this cycle, so fold it in directly
        urx_data_next = fmt8_reg ? {sdi_s, rx_sh_reg[8:2]} : rx_sh_reg[8:1];
        urx_perr_next = fmt8_reg ? 1'b0 : (sdi_s ^ (^rx_sh_reg[8:1]));
      end else if (rx_bit_reg != 4'h0) begin
        rx_sh_next = {sdi_s, rx_sh_reg[8:1]};
      end
    end else begin
      rx_cnt_next = rx_cnt_reg + 13'h1;
    end
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_busy_reg <= 1'b0;
      rx_cnt_reg <= 13'h0;
      rx_bit_reg <= 4'h0;
      rx_sh_reg <= 9'h0;
      urx_valid_reg <= 1'b0;
      urx_data_reg <= 8'h0;
      urx_perr_reg <= 1'b0;
    end else begin
      rx_busy_reg <= rx_busy_next;
      rx_cnt_reg <= rx_cnt_next;
      rx_bit_reg <= rx_bit_next;
      rx_sh_reg <= rx_sh_next;
      urx_valid_reg <= urx_valid_next;
      urx_data_reg <= urx_data_next;
      urx_perr_reg <= urx_perr_next;
    end
  end

  // spi master, mode 0, lsb first
  hsis_pkg::hsis_spi_t spi_reg, spi_next;
  logic [12:0] sp_cnt_reg, sp_cnt_next;
  logic [3:0] sp_bit_reg, sp_bit_next;
  logic [7:0] sp_out_reg, sp_out_next;
  logic [7:0] sp_in_reg, sp_in_next;
  logic req_old_reg;
  logic pend_reg, pend_next;
  logic srx_valid_reg, srx_valid_next;
  logic [12:0] half;
  assign half = fast_reg ? hsis_pkg::spi_fast_half : hsis_pkg::spi_slow_half;
  logic req_fall;
  assign req_fall = req_old_reg && !req_s;
  always_comb begin
    spi_next = spi_reg;
    sp_cnt_next = sp_cnt_reg;
    sp_bit_next = sp_bit_reg;
    sp_out_next = sp_out_reg;
    sp_in_next = sp_in_reg;
    srx_valid_next = 1'b0;
    pend_next = pend_reg || (is_spi && req_fall);
    unique case (spi_reg)
      hsis_pkg::hsis_spi_idle: begin
        if (is_spi && (pend_reg || tx_valid)) begin
          spi_next = hsis_pkg::hsis_spi_low;
          pend_next = is_spi && req_fall;
          sp_out_next = tx_valid ? tx_data : 8'h00;
          sp_cnt_next = 13'h0;
          sp_bit_next = 4'h0;
        end
      end
      hsis_pkg::hsis_spi_low: begin
        if (sp_cnt_reg == half - 13'h1) begin
          sp_cnt_next = 13'h0;
          spi_next = hsis_pkg::hsis_spi_high;
          sp_in_next = {sdi_s, sp_in_reg[7:1]};
        end else begin
          sp_cnt_next = sp_cnt_reg + 13'h1;
        end
      end
      hsis_pkg::hsis_spi_high: begin
        if (sp_cnt_reg == half - 13'h1) begin
          sp_cnt_next = 13'h0;
          if (sp_bit_reg == hsis_pkg::data_bits - 4'h1) begin
            spi_next = hsis_pkg::hsis_spi_idle;
            srx_valid_next = 1'b1;
          end else begin
            spi_next = hsis_pkg::hsis_spi_low;
            sp_bit_next = sp_bit_reg + 4'h1;
            sp_out_next = {1'b0, sp_out_reg[7:1]};
          end
        end else begin
          sp_cnt_next = sp_cnt_reg + 13'h1;
        end
      end
    endcase
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      spi_reg <= hsis_pkg::hsis_spi_idle;
      sp_cnt_reg <= 13'h0;
      sp_bit_reg <= 4'h0;
      sp_out_reg <= 8'h0;
      sp_in_reg <= 8'h0;
      req_old_reg <= 1'b1;
      pend_reg <= 1'b0;
      srx_valid_reg <= 1'b0;
    end else begin
      spi_reg <= spi_next;
      sp_cnt_reg <= sp_cnt_next;
      sp_bit_reg <= sp_bit_next;
      sp_out_reg <= sp_out_next;
      sp_in_reg <= sp_in_next;
      req_old_reg <= req_s;
      pend_reg <= pend_next;
      srx_valid_reg <= srx_valid_next;
    end
  end

  // output registers
  logic sclk_next, ss_next, sdo_next, btx_next, tready_next, fcoe_next;
  logic rvalid_next, rperr_next, fse_next;
  logic [7:0] rdata_next;
  always_comb begin
    sclk_next = spi_next == hsis_pkg::hsis_spi_high;
    fcoe_next = is_spi;
    ss_next = !(is_spi && spi_next != hsis_pkg::hsis_spi_idle);
    sdo_next = 1'b1;
    if (is_uart) begin
      sdo_next = utx_line_next;
    end else if (is_spi) begin
      sdo_next = sp_out_next[0];
    end else if (is_analog) begin
      sdo_next = brx_s;
    end
    btx_next = is_analog ? sdi_s : 1'b1;
    tready_next = (is_uart && !tx_busy_next) || (is_spi && spi_next == hsis_pkg::hsis_spi_idle);
    rvalid_next = urx_valid_next || srx_valid_next;
    rdata_next = srx_valid_next ? sp_in_next : urx_data_next;
    rperr_next = urx_valid_next && urx_perr_next;
    fse_next = is_uart && fmt8_reg;
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      format_clock_out <= 1'b0;
      format_clock_oe <= 1'b0;
      rate_select_oe <= 1'b0;
      slave_select_out <= 1'b1;
      device_to_host_serial <= 1'b1;
      bus_tx_level <= 1'b1;
      tx_ready <= 1'b0;
      rx_valid <= 1'b0;
      rx_data <= 8'h0;
      rx_parity_err <= 1'b0;
      frame_state_enable <= 1'b0;
      active_mode <= 4'h0;
    end else begin
      format_clock_out <= sclk_next;
      format_clock_oe <= fcoe_next;
      rate_select_oe <= fcoe_next;
      slave_select_out <= ss_next;
      device_to_host_serial <= sdo_next;
      bus_tx_level <= btx_next;
      tx_ready <= tready_next;
      rx_valid <= rvalid_next;
      rx_data <= rdata_next;
      rx_parity_err <= rperr_next;
      frame_state_enable <= fse_next;
      // shown one edge after the latch, together with the mode-dependent pin enables
      active_mode <= latched_reg ? mode_reg : 4'h0;
    end
  end
endmodule : hsis_top

/* File: hsis_top_props.sv */
// concurrent checks on the ports of the host serial interface select block
module hsis_top_props (
  input wire logic mclk,
  input wire logic rst,
  input wire logic transfer_request_in,
  input wire logic iface_select_a,
  input wire logic iface_select_b,
  input wire logic format_clock_out,
  input wire logic format_clock_oe,
  input wire logic rate_select_oe,
  input wire logic slave_select_out,
  input wire logic host_to_device_serial,
  input wire logic device_to_host_serial,
  input wire logic bus_rx_level,
  input wire logic bus_tx_level,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic frame_state_enable,
  input wire logic [3:0] active_mode
);
  logic [9:0] high_reg, high_next;
  logic [3:0] rise_reg, rise_next;
  logic clk_d_reg, clk_d_next;
  // cycles the spi clock has stood high, and rising edges within one select
  always_comb begin
    high_next = format_clock_out ? high_reg + 10'h1 : 10'h0;
    clk_d_next = format_clock_out;
    rise_next = slave_select_out ? 4'h0 : rise_reg + {3'h0, format_clock_out & ~clk_d_reg};
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      high_reg <= 10'h0;
      rise_reg <= 4'h0;
      clk_d_reg <= 1'b0;
    end else begin
      high_reg <= high_next;
      rise_reg <= rise_next;
      clk_d_reg <= clk_d_next;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  uart_sel_a: assert property (active_mode == 4'h1 |-> !(transfer_request_in | iface_select_a | iface_select_b))
    else $error("uart mode with wrong straps");
  spi_sel_a: assert property (active_mode == 4'h4 |-> (iface_select_a ^ iface_select_b) && format_clock_oe)
    else $error("spi mode with wrong straps");
  analog_sel_a: assert property (active_mode == 4'h2 |-> transfer_request_in && !iface_select_a && !iface_select_b)
    else $error("analog mode with wrong straps");
  frame_state_a: assert property (frame_state_enable |-> active_mode == 4'h1)
    else $error("frame state offered outside uart");
  spi_idle_a: assert property (active_mode != 4'h4 |-> slave_select_out && !format_clock_oe && !format_clock_out)
    else $error("spi pins active outside spi mode");
  clk_idle_a: assert property (slave_select_out |-> !format_clock_out)
    else $error("spi clock not idle low");
  half_per_a: assert property ($fell(format_clock_out) |-> {3'h0, high_reg} ==
    (iface_select_b ? hsis_pkg::spi_fast_half : hsis_pkg::spi_slow_half)) else $error("spi half period wrong");
  eight_clk_a: assert property ($rose(slave_select_out) |-> rise_reg == 4'h8)
    else $error("transfer not eight clocks");
  analog_path_a: assert property ($past(active_mode, 4) == 4'h2 |-> bus_tx_level == $past(host_to_device_serial, 3)
    && device_to_host_serial == $past(bus_rx_level, 3)) else $error("analog path broken");
  uart_start_a: assert property (tx_valid && tx_ready && active_mode == 4'h1 |-> ##[1:3] !device_to_host_serial)
    else $error("uart start bit missing");
  sel_pin_oe_a: assert property (rate_select_oe == format_clock_oe)
    else $error("select pin enable differs from clock pin enable");
  cover property ($rose(slave_select_out));
  cover property (tx_valid && tx_ready && active_mode == 4'h1);
  cover property ($fell(bus_tx_level) && active_mode == 4'h2);
endmodule : hsis_top_props
bind hsis_top hsis_top_props chk (.mclk, .rst, .transfer_request_in, .iface_select_a, .iface_select_b,
  .format_clock_out, .format_clock_oe, .rate_select_oe, .slave_select_out, .host_to_device_serial,
  .device_to_host_serial,
  .bus_rx_level, .bus_tx_level, .tx_valid, .tx_ready, .frame_state_enable, .active_mode);

/* File: hsis_host_model.sv */
// host side model: spi slave and uart line driver
module hsis_host_model (
  input wire logic sclk,
  input wire logic ssel_n,
  input wire logic miso,
  input wire logic uart_en,
  input wire logic uart_line,
  input wire logic [7:0] slave_byte,
  output logic mosi,
  output logic [7:0] got_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh_reg;
  logic bit_reg = 1'b0;
  // slave only: never drives clock or select
  always @(negedge ssel_n) begin
    sh_reg = slave_byte;
    bit_reg = slave_byte[0];
  end
  always @(posedge sclk) if (!ssel_n) begin
    got_byte = {miso, got_byte[7:1]};
    sh_reg = sh_reg >> 1;
  end
  always @(negedge sclk) if (!ssel_n) bit_reg = sh_reg[0];
  // released line shows the inverse of its last bit
  assign mosi = uart_en ? uart_line : (ssel_n ? ~bit_reg : bit_reg);
endmodule : hsis_host_model

/* File: host_serial_interface_select_tb.sv */
// self-checking bench for the host serial interface select block
module host_serial_interface_select_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic transfer_request_in = 1'b1;
  logic iface_select_a = 1'b0, iface_select_b = 1'b0, uart_format_select = 1'b0, uart_rate_select = 1'b0;
  logic bus_rx_level = 1'b0, tx_valid = 1'b0, uart_line = 1'b1, uart_en = 1'b1, got_perr;
  logic [7:0] tx_data = 8'h00, slave_byte = 8'h00, got_byte, got_rx, rx_data, d;
  logic format_clock_out, format_clock_oe, rate_select_oe, slave_select_out, host_to_device_serial;
  logic device_to_host_serial, bus_tx_level, tx_ready, rx_valid, rx_parity_err, frame_state_enable;
  logic [3:0] active_mode;
  logic [10:0] cap;
  logic [12:0] n;
  int failures = 0, tests_run = 0, cycles = 0, rx_cnt = 0, seed = 32'h76935c71;
  initial begin
    forever #4 mclk = ~mclk;
  end
  hsis_top dut (.mclk, .rst, .transfer_request_in, .iface_select_a, .iface_select_b, .uart_format_select,
    .uart_rate_select, .format_clock_out, .format_clock_oe, .rate_select_oe, .slave_select_out,
    .host_to_device_serial, .device_to_host_serial, .bus_rx_level, .bus_tx_level, .tx_valid, .tx_data,
    .tx_ready, .rx_valid, .rx_data, .rx_parity_err, .frame_state_enable, .active_mode);
  hsis_host_model host (.sclk(format_clock_out), .ssel_n(slave_select_out), .miso(device_to_host_serial),
    .uart_en(uart_en), .uart_line(uart_line), .slave_byte(slave_byte), .mosi(host_to_device_serial),
    .got_byte(got_byte));
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  always @(posedge mclk) begin
    cycles++;
    if (rx_valid === 1'b1) begin
      got_rx = rx_data;
      got_perr = rx_parity_err;
      rx_cnt++;
    end
    if (cycles == 110000) begin
      failures++;
      print_verdict();
    end
  end
  task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask : tick
  function automatic logic [3:0] exp_mode(input logic [4:0] s);
    if (s[3] && s[2]) return 4'h8;
    if (s[3] ^ s[2]) return 4'h4;
    return s[4] ? 4'h2 : 4'h1;
  endfunction : exp_mode
  function automatic logic [10:0] frame(input logic [7:0] v, input logic nine, input logic bad);
    return {1'b1, nine ? (^v) ^ bad : 1'b1, v, 1'b0};
  endfunction : frame
  task automatic restart(input logic [4:0] s, input int hold);
    {transfer_request_in, iface_select_b, iface_select_a, uart_format_select, uart_rate_select} = s;
    rst = 1'b1;
    tick(hold);
    rst = 1'b0;
    tick(8);
    chk(active_mode, exp_mode(s));
  endtask : restart
  task automatic send(input logic [7:0] v);
    tx_data = v;
    tx_valid = 1'b1;
    tick(1);
    tx_valid = 1'b0;
  endtask : send
  task automatic req();
    transfer_request_in = 1'b0;
    tick(2);
    transfer_request_in = 1'b1;
  endtask : req
  task automatic wait_xfer();
    int k = 0;
    while (slave_select_out !== 1'b0 && k < 40) begin
      tick(1);
      k++;
    end
    while (slave_select_out !== 1'b1 && k < 9000) begin
      tick(1);
      k++;
    end
    tick(4);
    chk(k > 16 && k < 9000, 1'b1);
  endtask : wait_xfer
  task automatic uart_char(input logic nine, input logic bad);
    logic [7:0] hd;
    logic [10:0] hf;
    hd = 8'($random(seed));
    hf = frame(hd, nine, bad);
    d = 8'($random(seed));
    send(d);
    fork
      for (int b = 0; b < 11; b++) begin
        uart_line = hf[b];
        tick(hsis_pkg::uart_fast_cyc);
      end
      begin
        n = 0;
        while (device_to_host_serial !== 1'b0 && n < 20) begin
          tick(1);
          n++;
        end
        tick(hsis_pkg::uart_fast_cyc / 2);
        for (int b = 0; b < 11; b++) begin
          cap[b] = device_to_host_serial;
          tick(hsis_pkg::uart_fast_cyc);
        end
      end
    join
    chk(cap, frame(d, nine, 1'b0));
    chk(got_rx, hd);
    chk(got_perr, bad);
  endtask : uart_char
  initial begin
    for (int i = 0; i < 32; i++) begin
      restart(5'(i), i == 0 ? 3 : 5);
      chk(frame_state_enable, exp_mode(5'(i)) == 4'h1 && i[1]);
      {uart_format_select, uart_rate_select} = ~{uart_format_select, uart_rate_select};
      tick(6);
      chk(active_mode, exp_mode(5'(i)));
      chk(frame_state_enable, exp_mode(5'(i)) == 4'h1 && i[1]);
    end
    restart(5'b00011, 5);
    uart_char(1'b0, 1'b0);
    restart(5'b00001, 5);
    uart_char(1'b1, 1'b1);
    restart(5'b00010, 5);
    send(8'hff);
    n = 0;
    while (device_to_host_serial !== 1'b0 && n < 20) begin
      tick(1);
      n++;
    end
    n = 0;
    while (device_to_host_serial === 1'b0 && n < 7000) begin
      tick(1);
      n++;
    end
    chk(n, hsis_pkg::uart_slow_cyc);
    restart(5'b10000, 5);
    repeat (8) begin
      {uart_line, bus_rx_level} = 2'($random(seed));
      tick(4);
      chk({bus_tx_level, device_to_host_serial}, {uart_line, bus_rx_level});
    end
    uart_en = 1'b0;
    restart(5'b11000, 5);
    rx_cnt = 0;
    slave_byte = 8'($random(seed));
    req();
    wait_xfer();
    chk(got_byte, 8'h00);
    chk(got_rx, slave_byte);
    d = 8'($random(seed));
    send(d);
    tick(300);
    req();
    wait_xfer();
    chk(got_byte, d);
    wait_xfer();
    chk(got_byte, 8'h00);
    chk(rx_cnt, 3);
    restart(5'b10100, 5);
    slave_byte = 8'($random(seed));
    d = 8'($random(seed));
    send(d);
    wait_xfer();
    chk(got_byte, d);
    chk(got_rx, slave_byte);
    print_verdict();
  end
endmodule : host_serial_interface_select_tb
